// ---- supervisor_regs.svh ----
// Timing constants for the supply reset supervisor
`ifndef SUPERVISOR_REGS_SVH
`define SUPERVISOR_REGS_SVH

`define CLK_PERIOD_PS      64'd4000
`define RELEASE_DELAY_MS   64'd180
`define RELEASE_DELAY_CYC  ((`RELEASE_DELAY_MS * 64'd1000000000) / `CLK_PERIOD_PS)
`define WDT_TIMEOUT_MS     64'd800
`define WDT_TIMEOUT_CYC    ((`WDT_TIMEOUT_MS * 64'd1000000000 + `CLK_PERIOD_PS - 64'd1) / `CLK_PERIOD_PS)
`define CNT_W              32
`define CNT_ZERO           32'h0000_0000
`define CNT_ONE            32'h0000_0001
`define CNT_MAX            32'hffff_ffff
`define SYNC_RESET         3'h3
`define KICK_RESET         1'h0

`endif

// ---- supervisor_pkg.sv ----
// Types shared by the supply reset supervisor
package supervisor_pkg;
    typedef enum logic [1:0] {
        HOLD,
        DELAY,
        RUN
    } rst_state_t;
endpackage

// ---- sync_bus_if.sv ----
// Synchronised input levels and edge event passed to the supervisor core
`timescale 1ns/1ps
`default_nettype none
interface sync_bus_if;
    logic supplyLow;
    logic manualLow;
    logic kickEdge;
    modport src (output supplyLow, output manualLow, output kickEdge);
    modport dst (input supplyLow, input manualLow, input kickEdge);
endinterface
`default_nettype wire

// ---- input_sync.sv ----
// Two-stage synchronisers and kick edge detector
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_regs.svh"
module input_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rstSync_n,
    // Raw pins
    input  wire logic supplyLowIn,
    input  wire logic manualResetIn_n,
    input  wire logic kickIn,
    // Synchronised outputs
    sync_bus_if.src   bus
);
    logic [2:0] stage1;
    logic [2:0] stage2;
    logic       kickPrev;
    logic [2:0] next_stage1;
    logic [2:0] next_stage2;
    logic       next_kickPrev;

    always_comb begin
        next_stage1   = {kickIn, manualResetIn_n, supplyLowIn};
        next_stage2   = stage1;
        next_kickPrev = stage2[2];
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            stage1   <= `SYNC_RESET;
            stage2   <= `SYNC_RESET;
            kickPrev <= `KICK_RESET;
        end else begin
            stage1   <= next_stage1;
            stage2   <= next_stage2;
            kickPrev <= next_kickPrev;
        end
    end

    assign bus.supplyLow = stage2[0];
    assign bus.manualLow = ~stage2[1];
    assign bus.kickEdge  = stage2[2] ^ kickPrev;
endmodule
`default_nettype wire

// ---- supply_reset_supervisor_wdt.sv ----
// Supply reset supervisor with manual reset and watchdog
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_regs.svh"
// What this block does
// - Reset output goes low while supply is below the falling threshold.
// - After supply recovers past threshold plus hysteresis, hold reset for release delay.
// - Optional active-high output mirrors the active-low reset exactly.
// - Manual reset low forces reset regardless of supply or watchdog.
// - After manual reset returns high, release only after the release delay.
// - Kick input stuck high or low past the timeout triggers reset.
// - Watchdog counter clears on reset and on every kick edge.
// - Below minimum supply the outputs are undefined; no guarantee is made.
// - Watchdog, manual reset and active-high output are build-time options.
// - Release delay is nominally 180 ms, timed from the end of the cause.
// - Watchdog expiry asserts reset for the release delay and clears the counter.
module supply_reset_supervisor_wdt #(
    parameter bit          HAS_WATCHDOG    = 1'b1,
    parameter bit          HAS_MANUAL      = 1'b1,
    parameter bit          HAS_ACTIVE_HIGH = 1'b1,
    parameter logic [31:0] RELEASE_CYCLES  = 32'(`RELEASE_DELAY_CYC),
    parameter logic [31:0] TIMEOUT_CYCLES  = 32'(`WDT_TIMEOUT_CYC)
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Monitored inputs
    input  wire logic supplyLowIn,
    input  wire logic manual_reset_n,
    input  wire logic watchdog_kick_in,
    // Reset outputs
    output var  logic resetOut_n,
    output var  logic resetOut
);
    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic rstMeta_n;
    logic rstSync_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_n <= 1'b0;
            rstSync_n <= 1'b0;
        end else begin
            rstMeta_n <= 1'b1;
            rstSync_n <= rstMeta_n;
        end
    end

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    sync_bus_if syncBus ();

    input_sync i_input_sync (
        .clk             (clk),
        .rstSync_n       (rstSync_n),
        .supplyLowIn     (supplyLowIn),
        .manualResetIn_n (manual_reset_n),
        .kickIn          (watchdog_kick_in),
        .bus             (syncBus)
    );

    // ----------------------------------------
    // Reset sequencer and watchdog
    // ----------------------------------------
    supervisor_pkg::rst_state_t state;
    supervisor_pkg::rst_state_t next_state;
    logic [`CNT_W-1:0]          delayCnt;
    logic [`CNT_W-1:0]          next_delayCnt;
    logic [`CNT_W-1:0]          wdtCnt;
    logic [`CNT_W-1:0]          next_wdtCnt;
    logic                       next_resetOut_n;
    logic                       next_resetOut;
    logic                       manualHold;
    logic                       wdtExpire;
    logic                       cause;

    // ----------------------------------------
    // Counter and state helpers
    // ----------------------------------------
    // Last cycle of a span of limit cycles counted up from zero
    function automatic logic countDone(
        input logic [`CNT_W-1:0] cnt,
        input logic [`CNT_W-1:0] limit
    );
        countDone = (cnt >= limit - `CNT_ONE);
    endfunction

    // Saturates so a counter left running can never wrap back to zero
    function automatic logic [`CNT_W-1:0] countStep(
        input logic [`CNT_W-1:0] cnt
    );
        if (cnt == `CNT_MAX) begin
            countStep = cnt;
        end else begin
            countStep = cnt + `CNT_ONE;
        end
    endfunction

    // Run is the only state in which reset is released
    function automatic logic isRun(
        input supervisor_pkg::rst_state_t s
    );
        isRun = (s == supervisor_pkg::RUN);
    endfunction

    // ----------------------------------------
    // Reset causes
    // ----------------------------------------
    // below the minimum supply this logic is unpowered; no output level is promised
    always_comb begin
        manualHold = HAS_MANUAL && syncBus.manualLow;
        wdtExpire  = HAS_WATCHDOG && isRun(state)
                     && countDone(wdtCnt, TIMEOUT_CYCLES);
        cause      = syncBus.supplyLow || manualHold;
    end

    // ----------------------------------------
    // Sequencer state
    // ----------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            supervisor_pkg::HOLD: begin
                if (!cause) begin
                    next_state = supervisor_pkg::DELAY;
                end
            end
            supervisor_pkg::DELAY: begin
                if (cause) begin
                    next_state = supervisor_pkg::HOLD;
                end else if (countDone(delayCnt, RELEASE_CYCLES)) begin
                    next_state = supervisor_pkg::RUN;
                end
            end
            supervisor_pkg::RUN: begin
                if (cause) begin
                    next_state = supervisor_pkg::HOLD;
                end else if (wdtExpire) begin
                    next_state = supervisor_pkg::DELAY;
                end
            end
            default: begin
                next_state = supervisor_pkg::HOLD;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state <= supervisor_pkg::HOLD;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------
    // Release delay counter
    // ----------------------------------------
    // Counts only while the delay runs on; any other move restarts it from zero
    always_comb begin
        if ((state == supervisor_pkg::DELAY) && (next_state == supervisor_pkg::DELAY)) begin
            next_delayCnt = countStep(delayCnt);
        end else begin
            next_delayCnt = `CNT_ZERO;
        end
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            delayCnt <= `CNT_ZERO;
        end else begin
            delayCnt <= next_delayCnt;
        end
    end

    // ----------------------------------------
    // Watchdog counter
    // ----------------------------------------
    // Held at zero outside run, so kicks during reset are ignored
    // Expiry and a kick in the same cycle: expiry wins
    always_comb begin
        if (!HAS_WATCHDOG || !isRun(state) || !isRun(next_state)) begin
            next_wdtCnt = `CNT_ZERO;
        end else if (syncBus.kickEdge) begin
            next_wdtCnt = `CNT_ZERO;
        end else begin
            next_wdtCnt = countStep(wdtCnt);
        end
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            wdtCnt <= `CNT_ZERO;
        end else begin
            wdtCnt <= next_wdtCnt;
        end
    end

    // ----------------------------------------
    // Reset outputs
    // ----------------------------------------
    always_comb begin
        next_resetOut_n = isRun(next_state);
        next_resetOut   = HAS_ACTIVE_HIGH && !isRun(next_state);
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            resetOut_n <= 1'b0;
            resetOut   <= HAS_ACTIVE_HIGH;
        end else begin
            resetOut_n <= next_resetOut_n;
            resetOut   <= next_resetOut;
        end
    end
endmodule
`default_nettype wire

// ---- supervisor_asserts.sv ----
// Port-level timing checks for the supervisor
`timescale 1ns/1ps
`default_nettype none
module supervisor_asserts #(
    parameter logic [31:0] RELEASE_CYCLES = 32'h14,
    parameter logic [31:0] TIMEOUT_CYCLES = 32'h32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Watched pins
    input wire logic supplyLowIn,
    input wire logic manual_reset_n,
    input wire logic watchdog_kick_in,
    input wire logic resetOut_n,
    input wire logic resetOut
);
    logic [31:0] lowCnt;
    logic [31:0] stillCnt;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Cycles in reset, and cycles with a still kick pin
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lowCnt   <= 32'h0;
            stillCnt <= 32'h0;
        end else begin
            lowCnt   <= resetOut_n ? 32'h0 : lowCnt + 32'h1;
            stillCnt <= (!resetOut_n || $changed(watchdog_kick_in)) ? 32'h0 : stillCnt + 32'h1;
        end
    end
    property p_sup; supplyLowIn [*4] |-> !resetOut_n; endproperty
    a_sup: assert property (p_sup) else $error("supply low missed");
    property p_man; !manual_reset_n [*4] |-> !resetOut_n; endproperty
    a_man: assert property (p_man) else $error("manual low missed");
    property p_mir; resetOut == !resetOut_n; endproperty
    a_mir: assert property (p_mir) else $error("mirror wrong on edge");
    property p_hi; resetOut_n |-> !resetOut; endproperty
    a_hi: assert property (p_hi) else $error("mirror high in run");
    property p_hold; $rose(resetOut_n) |-> lowCnt >= RELEASE_CYCLES; endproperty
    a_hold: assert property (p_hold) else $error("release too early");
    property p_mrel; $rose(manual_reset_n) && !resetOut_n |=> !resetOut_n [*8]; endproperty
    a_mrel: assert property (p_mrel) else $error("manual release early");
    property p_wdt; stillCnt < TIMEOUT_CYCLES + 32'h8; endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog never fired");
    property p_cause; $fell(resetOut_n) |-> $past(supplyLowIn, 2) || !$past(manual_reset_n, 2)
        || stillCnt >= TIMEOUT_CYCLES - 32'h2; endproperty
    a_cause: assert property (p_cause) else $error("reset without cause");
    c_rel: cover property ($rose(resetOut_n));
    c_man: cover property ($rose(manual_reset_n) && !resetOut_n);
    c_wdt: cover property ($fell(resetOut_n) && manual_reset_n && !supplyLowIn);
endmodule
`default_nettype wire

// ---- kick_host.sv ----
// Processor model that kicks the watchdog at random spacing
`timescale 1ns/1ps
`default_nettype none
module kick_host (
    // Clock
    input  wire logic clk,
    // Kicking allowed
    input  wire logic enable,
    // Kick pin
    output var  logic kick
);
    int gap = 5;
    initial kick = 1'b0;
    always @(negedge clk) begin
        if (enable && gap <= 0) begin
            kick <= !kick;
            gap  <= $urandom_range(40, 1);
        end else begin
            gap <= gap - 1;
        end
    end
endmodule
`default_nettype wire

// ---- supply_reset_supervisor_wdt_tb.sv ----
// Self-checking bench for the supervisor
`timescale 1ns/1ps
`default_nettype none
module supply_reset_supervisor_wdt_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic supLow = 1'b1;
    logic manN = 1'b1;
    logic kickOn = 1'b0;
    logic live = 1'b0;
    logic kick;
    logic rstN;
    logic rstH;
    logic expQ [$];
    int   error_cnt = 0;
    int   n_checks = 0;
    int   n;
    always #2 clk = !clk;
    supply_reset_supervisor_wdt #(.RELEASE_CYCLES(32'h14), .TIMEOUT_CYCLES(32'h32))
        i_supply_reset_supervisor_wdt (.clk(clk), .rst_n(rst_n), .supplyLowIn(supLow),
        .manual_reset_n(manN), .watchdog_kick_in(kick), .resetOut_n(rstN), .resetOut(rstH));
    kick_host i_kick_host (.clk(clk), .enable(kickOn), .kick(kick));
    task automatic check(input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic wait_level(input logic v);
        for (n = 0; rstN !== v && n < 200; n++) @(negedge clk);
        if (n == 200) begin
            check(v, rstN);
            stop_test();
        end
    endtask
    logic seenN = 1'b0;
    // Every output change seen at a falling edge takes the oldest note
    always @(negedge clk) begin
        if (live && rstN !== seenN) begin
            check(expQ.size() > 0 ? expQ.pop_front() : !rstN, rstN);
        end
        seenN = rstN;
    end
    initial begin
        void'($urandom(32'hb562d7f7));
        repeat (20) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        live = 1'b1;
        check(1'b1, rstH);
        repeat (8) @(negedge clk);
        expQ.push_back(1'b1);
        supLow = 1'b0;
        kickOn <= 1'b1;
        wait_level(1'b1);
        check(1'b1, n >= 20 && n <= 24);
        check(1'b0, rstH);
        $display("power-up done");
        for (int k = 0; k < 6; k++) begin
            @(negedge clk);
            expQ.push_back(1'b0);
            supLow = (k % 3 == 0);
            manN = (k % 3 != 1);
            kickOn <= (k % 3 != 2);
            wait_level(1'b0);
            check(1'b1, rstH);
            repeat (k % 3 == 2 ? 0 : $urandom_range(30, 8)) @(negedge clk);
            expQ.push_back(1'b1);
            supLow = 1'b0;
            manN = 1'b1;
            kickOn <= 1'b1;
            wait_level(1'b1);
            check(1'b1, n >= 20 && n <= 24);
            check(1'b0, rstH);
            $display("cause %0d done", k % 3);
        end
        repeat (400) @(negedge clk);
        check(1'b1, rstN);
        $display("steady kicking done");
        stop_test();
    end
endmodule
bind supply_reset_supervisor_wdt supervisor_asserts #(.RELEASE_CYCLES(RELEASE_CYCLES),
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_supervisor_asserts (.clk(clk), .rst_n(rst_n),
    .supplyLowIn(supplyLowIn), .manual_reset_n(manual_reset_n),
    .watchdog_kick_in(watchdog_kick_in), .resetOut_n(resetOut_n), .resetOut(resetOut));
`default_nettype wire
